// [verilog/sscc_top.sv]
// sscc_top: serial configuration port with command validation and apb view
// assumes: host is serial master, software reaches the apb side on pclk
//
// What this block does
// - serial port works in init, normal, stop; off in sleep, restart, fail-safe.
// - every transfer is one full-duplex 32-bit frame; select lines per slave.
// - frame starts on select low; shifting only while select stays low.
// - received word decoded only after select rises, never inside a frame.
// - data output released to high impedance when select rises.
// - data input sampled into receive shifter on each serial clock fall.
// - data output advances after each serial clock rise; no daisy chain.
// - bad or forbidden command discarded whole and fault flag set.
// - fault flag holds until host clears it by a serial command.
// - sleep from stop gives restart; stop or sleep from init gives normal; both fault.
// - watchdog write with bad parity faults; trigger and settings both dropped.
// - stop mode accepts only trigger, normal, soft reset, status access.
// - stop entry with all wake enables clear is accepted without fault.
// - stop entry with pending wake status asserts interrupt, no fault.
// - stop to normal write changes the mode only, other bits ignored.
// - sleep without wake source faults, goes restart; other mode bits lost, restart clears them.
// - timer as only wake source while timer off leaves sleep for restart.
// - timer on-time not below a nonzero period is rejected with fault.
// - frame of all zeros or all ones is stuck input, rejected, fault.
// - second pin config, or sync outputs without sync input, rejected with fault.
// - unused addresses ignored silently, no fault.
// - checksum strap: bad checksum sets checksum flag, command dropped; first command still leaves init.
// - bits 6..0 address, bit 7 write or clear, bits 23..8 data.
// - clock count not 0 or 32, or clock high at select edge, flags error.
// - in restart no serial traffic is interpreted.
// - written settings take effect on select rise, seen next frame.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module sscc_top import sscc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic select_low_input,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic wake_pin,
  input wire logic fail_safe_req,
  input wire logic checksum_strap_pin,
  output logic interrupt_out_low,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ------------------------------------------------------------
  // input synchronisation and frame engine
  // ------------------------------------------------------------
  logic sel_s, sclk_s, sdi_s, wake_s, fail_s, strap_s;
  logic [FRAME_BITS-1:0] rx_word, tx_word;
  logic frame_end, frame_ok, frame_err;
  sscc_mode_t mode_r, mode_nxt;
  logic port_en;

  sscc_sync #(.W(6), .RST_VAL(6'h20)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({select_low_input, sclk, sdi, wake_pin, fail_safe_req, checksum_strap_pin}),
    .dout({sel_s, sclk_s, sdi_s, wake_s, fail_s, strap_s})
  );

  // port off outside init, normal and stop
  assign port_en = (mode_r == M_INIT) || (mode_r == M_NORMAL) || (mode_r == M_STOP);

  sscc_shifter u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .enable(port_en),
    .sel_s(sel_s),
    .sclk_s(sclk_s),
    .sdi_s(sdi_s),
    .tx_word(tx_word),
    .rx_word(rx_word),
    .frame_end(frame_end),
    .frame_ok(frame_ok),
    .frame_err(frame_err),
    .sdo(sdo),
    .sdo_oe(sdo_oe)
  );

  // ------------------------------------------------------------
  // device state
  // ------------------------------------------------------------
  logic fault_r, crc_fail_r, err_r, strap_r, strap_done_r, pin_done_r, int_r;
  logic [12:0] mode_other_r;
  logic [15:0] wd_cfg_r, wake_en_r, bus_en_r, timer_r, pin_cfg_r, hs_cfg_r;
  logic [15:0] wake_status_reg_r, rd_data_r;
  logic [7:0] wd_cnt_r;
  logic [31:0] last_cmd_r;
  logic [$clog2(RESTART_CYC+1)-1:0] rst_cnt_r;

  // decoded fields of the received word
  logic [6:0] c_addr;
  logic c_wr;
  logic [15:0] c_data;
  logic [2:0] c_req;
  logic cmd_go, stuck, crc_bad, no_wake, timer_only_off, restart_entry;
  assign c_addr = rx_word[ADDR_MSB:ADDR_LSB];
  assign c_wr = rx_word[WR_BIT];
  assign c_data = rx_word[DATA_MSB:DATA_LSB];
  assign c_req = c_data[2:0];
  assign cmd_go = frame_end && frame_ok && (mode_r != M_RESTART);
  assign stuck = (rx_word == '0) || (rx_word == '1);
  assign crc_bad = sscc_crc8(rx_word[DATA_MSB:0]) != rx_word[CRC_MSB:CRC_LSB];
  assign no_wake = (wake_en_r == '0) && (bus_en_r == '0);
  assign timer_only_off = (wake_en_r == (16'h0001 << WK_TIMER_BIT)) && (bus_en_r == '0)
                          && (timer_r[7:0] == 8'h00);

  // known serial register addresses
  function automatic logic addr_known(input logic [6:0] a);
    case (a)
      A_MODE, A_WD, A_WAKE_EN, A_BUS, A_TIMER, A_PIN, A_HS, A_WAKE_STATUS_REG, A_DEV_STAT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : addr_known

  // readback of a serial register
  function automatic logic [15:0] reg_view(input logic [6:0] a);
    case (a)
      A_MODE: return {mode_other_r, 3'(mode_r)};
      A_WD: return wd_cfg_r;
      A_WAKE_EN: return wake_en_r;
      A_BUS: return bus_en_r;
      A_TIMER: return timer_r;
      A_PIN: return pin_cfg_r;
      A_HS: return hs_cfg_r;
      A_WAKE_STATUS_REG: return wake_status_reg_r;
      A_DEV_STAT: return {14'h0000, crc_fail_r, fault_r};
      default: return 16'h0000;
    endcase
  endfunction : reg_view

  // ------------------------------------------------------------
  // command validation
  // ------------------------------------------------------------
  logic f_set, crc_set, clr_dev, clr_wk, int_set;
  logic w_other, w_wd, w_wken, w_bus, w_tmr, w_pin, w_hs;

  always_comb begin
    f_set = 1'b0;
    crc_set = 1'b0;
    clr_dev = 1'b0;
    clr_wk = 1'b0;
    int_set = 1'b0;
    w_other = 1'b0;
    w_wd = 1'b0;
    w_wken = 1'b0;
    w_bus = 1'b0;
    w_tmr = 1'b0;
    w_pin = 1'b0;
    w_hs = 1'b0;
    mode_nxt = mode_r;
    if (cmd_go) begin
      if (stuck) begin
        f_set = 1'b1;
      end else if (strap_r && crc_bad) begin
        crc_set = 1'b1;
        if (mode_r == M_INIT) begin
          mode_nxt = M_NORMAL;
        end
      end else if (addr_known(c_addr) && c_wr) begin
        case (c_addr)
          A_DEV_STAT: clr_dev = 1'b1;
          A_WAKE_STATUS_REG: clr_wk = 1'b1;
          A_WD: begin
            if (^c_data) begin
              f_set = 1'b1;
            end else begin
              w_wd = 1'b1;
            end
          end
          A_MODE: begin
            case (c_req)
              REQ_NORMAL: begin
                mode_nxt = M_NORMAL;
                w_other = (mode_r != M_STOP);
              end
              REQ_STOP: begin
                if (mode_r == M_INIT) begin
                  f_set = 1'b1;
                  mode_nxt = M_NORMAL;
                end else if (mode_r == M_NORMAL) begin
                  mode_nxt = M_STOP;
                  int_set = (wake_status_reg_r != '0);
                  w_other = 1'b1;
                end
              end
              REQ_SLEEP: begin
                if (mode_r == M_INIT) begin
                  f_set = 1'b1;
                  mode_nxt = M_NORMAL;
                end else if (mode_r == M_STOP) begin
                  f_set = 1'b1;
                  mode_nxt = M_RESTART;
                end else begin
                  f_set = no_wake;
                  mode_nxt = no_wake ? M_RESTART : M_SLEEP;
                  w_other = 1'b1;
                end
              end
              REQ_SOFTRST: mode_nxt = M_RESTART;
              default: f_set = 1'b1;
            endcase
          end
          default: begin
            if (mode_r == M_STOP) begin
              f_set = 1'b1;
            end else if (c_addr == A_TIMER) begin
              f_set = (c_data[15:8] >= c_data[7:0]) && (c_data[7:0] != 8'h00);
              w_tmr = !f_set;
            end else if (c_addr == A_PIN) begin
              f_set = pin_done_r;
              w_pin = !pin_done_r;
            end else if (c_addr == A_HS) begin
              f_set = (c_data != '0) && !pin_cfg_r[PIN_SYNC_BIT];
              w_hs = !f_set;
            end else begin
              w_wken = (c_addr == A_WAKE_EN);
              w_bus = (c_addr == A_BUS);
            end
          end
        endcase
      end
    end else if (mode_r == M_SLEEP && (timer_only_off || wake_status_reg_r != '0)) begin
      mode_nxt = M_RESTART;
    end else if (mode_r == M_RESTART && rst_cnt_r == '0) begin
      mode_nxt = M_NORMAL;
    end
    if (fail_s) begin
      mode_nxt = M_FAILSAFE;
    end else if (mode_r == M_FAILSAFE) begin
      mode_nxt = M_RESTART;
    end
  end

  assign restart_entry = (mode_nxt == M_RESTART) && (mode_r != M_RESTART);

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  // device mode and restart timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= M_INIT;
      rst_cnt_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      if (restart_entry) begin
        rst_cnt_r <= ($clog2(RESTART_CYC+1))'(RESTART_CYC - 1);
      end else if (rst_cnt_r != '0) begin
        rst_cnt_r <= rst_cnt_r - 1'b1;
      end
    end
  end

  // sticky fault and checksum flags; a new set beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 1'b0;
      crc_fail_r <= 1'b0;
    end else begin
      fault_r <= f_set | (fault_r & ~clr_dev);
      crc_fail_r <= crc_set | (crc_fail_r & ~clr_dev);
    end
  end

  // frame error shown at the head of the next response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= 1'b0;
    end else if (frame_end) begin
      err_r <= frame_err;
    end
  end

  // strap followed until the first decoded frame, then frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_r <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_r <= strap_s;
      strap_done_r <= cmd_go;
    end
  end

  // configuration, applied only on a validated frame end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_other_r <= '0;
      wd_cfg_r <= CFG_RST;
      wake_en_r <= CFG_RST;
      bus_en_r <= CFG_RST;
      timer_r <= CFG_RST;
      pin_cfg_r <= CFG_RST;
      hs_cfg_r <= CFG_RST;
      pin_done_r <= 1'b0;
    end else if (restart_entry) begin
      mode_other_r <= '0;
      wd_cfg_r <= CFG_RST;
      wake_en_r <= CFG_RST;
      bus_en_r <= CFG_RST;
      timer_r <= CFG_RST;
      hs_cfg_r <= CFG_RST;
    end else begin
      if (w_other) mode_other_r <= c_data[15:3];
      if (w_wd) wd_cfg_r <= c_data;
      if (w_wken) wake_en_r <= c_data;
      if (w_bus) bus_en_r <= c_data;
      if (w_tmr) timer_r <= c_data;
      if (w_hs) hs_cfg_r <= c_data;
      if (w_pin) begin
        pin_cfg_r <= c_data;
        pin_done_r <= 1'b1;
      end
    end
  end

  // watchdog triggers, last command and previous readback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_r <= '0;
      last_cmd_r <= '0;
      rd_data_r <= '0;
    end else if (cmd_go) begin
      if (w_wd) wd_cnt_r <= wd_cnt_r + 8'h01;
      last_cmd_r <= rx_word;
      rd_data_r <= reg_view(c_addr);
    end
  end

  // ------------------------------------------------------------
  // wake status, interrupt and response word
  // ------------------------------------------------------------
  logic apb_wake_set, apb_go;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_status_reg_r <= '0;
    end else begin
      wake_status_reg_r <= (wake_status_reg_r & ~{16{clr_wk}})
                   | ({15'h0000, wake_s & wake_en_r[WK_PIN_BIT]} << WK_PIN_BIT)
                   | (apb_wake_set ? pwdata[15:0] : 16'h0000);
    end
  end

  // interrupt held low until wake status is cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_r <= 1'b0;
      interrupt_out_low <= 1'b1;
    end else begin
      int_r <= int_set | (int_r & (wake_status_reg_r != '0) & ~clr_wk);
      interrupt_out_low <= ~int_r;
    end
  end

  logic [7:0] stat8;
  assign stat8 = {fault_r | crc_fail_r, 3'h0, wake_status_reg_r != '0, 2'h0, err_r};
  assign tx_word = {sscc_crc8({rd_data_r, stat8}), rd_data_r, stat8};

  // ------------------------------------------------------------
  // apb slave, no wait states
  // ------------------------------------------------------------
  assign apb_go = psel && penable && pready;
  assign apb_wake_set = apb_go && pwrite && (paddr == APB_WAKE_SET);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr inside {APB_STATUS, APB_WAKE_SET,
                 APB_LAST_CMD, APB_CONFIG});
      case (paddr)
        APB_STATUS: prdata <= {16'h0000, wd_cnt_r, 1'b0, strap_r, err_r, crc_fail_r,
                               fault_r, 3'(mode_r)};
        APB_WAKE_SET: prdata <= {16'h0000, wake_status_reg_r};
        APB_LAST_CMD: prdata <= last_cmd_r;
        APB_CONFIG: prdata <= {wake_en_r, bus_en_r};
        default: prdata <= '0;
      endcase
    end
  end
endmodule : sscc_top

// [inc/sscc_pkg.sv]
// sscc_pkg: shared constants, modes and helpers for the serial command checker
// assumes: 200 MHz pclk, 32-bit host frames, apb register access
package sscc_pkg;

  // ------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_MSB = 6;
  localparam int WR_BIT = 7;
  localparam int DATA_LSB = 8;
  localparam int DATA_MSB = 23;
  localparam int CRC_LSB = 24;
  localparam int CRC_MSB = 31;

  // ------------------------------------------------------------
  // serial register addresses and fields
  // ------------------------------------------------------------
  localparam logic [6:0] A_MODE = 7'h01;
  localparam logic [6:0] A_WD = 7'h02;
  localparam logic [6:0] A_WAKE_EN = 7'h03;
  localparam logic [6:0] A_BUS = 7'h04;
  localparam logic [6:0] A_TIMER = 7'h05;
  localparam logic [6:0] A_PIN = 7'h06;
  localparam logic [6:0] A_HS = 7'h07;
  localparam logic [6:0] A_WAKE_STATUS_REG = 7'h40;
  localparam logic [6:0] A_DEV_STAT = 7'h41;
  localparam logic [2:0] REQ_NORMAL = 3'h0;
  localparam logic [2:0] REQ_STOP = 3'h1;
  localparam logic [2:0] REQ_SLEEP = 3'h2;
  localparam logic [2:0] REQ_SOFTRST = 3'h3;
  localparam int WK_TIMER_BIT = 0;
  localparam int WK_PIN_BIT = 1;
  localparam int PIN_SYNC_BIT = 0;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [7:0] CRC_POLY = 8'h2f;
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [7:0] CRC_XOR = 8'hff;

  // ------------------------------------------------------------
  // apb map and timing
  // ------------------------------------------------------------
  localparam logic [11:0] APB_STATUS = 12'h000;
  localparam logic [11:0] APB_WAKE_SET = 12'h004;
  localparam logic [11:0] APB_LAST_CMD = 12'h008;
  localparam logic [11:0] APB_CONFIG = 12'h00c;
  localparam int CLK_MHZ = 200;
  localparam int RESTART_NS = 10000;
  localparam int RESTART_CYC = (RESTART_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    M_INIT, M_NORMAL, M_STOP, M_SLEEP, M_RESTART, M_FAILSAFE
  } sscc_mode_t;

  // checksum over the low 24 frame bits, msb first
  function automatic logic [7:0] sscc_crc8(input logic [23:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c ^ CRC_XOR;
  endfunction : sscc_crc8

endpackage : sscc_pkg

// [verilog/sscc_sync.sv]
// sscc_sync: three-stage input synchroniser with agreement filter
// assumes: inputs are asynchronous to pclk
`timescale 1ns/10ps
module sscc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;

  // stage chain; ff1 feeds ff2 only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff1_r <= RST_VAL;
      ff2_r <= RST_VAL;
      ff3_r <= RST_VAL;
    end else begin
      ff1_r <= din;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
    end
  end

  // a bit changes once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= RST_VAL;
    end else begin
      dout <= (ff2_r & ff3_r) | (dout & (ff2_r | ff3_r));
    end
  end
endmodule : sscc_sync

// [verilog/sscc_shifter.sv]
// sscc_shifter: serial frame engine, edges found on the pclk-sampled link
// assumes: synchronised select, clock and data inputs
`timescale 1ns/10ps
module sscc_shifter import sscc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic sel_s,
  input wire logic sclk_s,
  input wire logic sdi_s,
  input wire logic [FRAME_BITS-1:0] tx_word,
  output logic [FRAME_BITS-1:0] rx_word,
  output logic frame_end,
  output logic frame_ok,
  output logic frame_err,
  output logic sdo,
  output logic sdo_oe
);
  logic sel_q;
  logic sclk_q;
  logic active_r;
  logic clkhi_r;
  logic [CNT_W-1:0] cnt_r;
  logic [FRAME_BITS-1:0] tx_r;
  logic sel_fall;
  logic sel_rise;
  logic sclk_fall;
  logic sclk_rise;

  assign sel_fall = sel_q & ~sel_s;
  assign sel_rise = ~sel_q & sel_s;
  assign sclk_fall = sclk_q & ~sclk_s;
  assign sclk_rise = ~sclk_q & sclk_s;

  // previous levels for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      sel_q <= sel_s;
      sclk_q <= sclk_s;
    end
  end

  // frame window, only while select is low and the port is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r <= 1'b0;
      clkhi_r <= 1'b0;
    end else if (sel_fall && enable) begin
      active_r <= 1'b1;
      clkhi_r <= sclk_s;
    end else if (active_r && (sel_rise || !enable)) begin
      active_r <= 1'b0;
    end
  end

  // bit counter and receive shift on clock falls, lsb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      rx_word <= '0;
    end else if (sel_fall && enable) begin
      cnt_r <= '0;
    end else if (active_r && sclk_fall) begin
      rx_word <= {sdi_s, rx_word[FRAME_BITS-1:1]};
      if (cnt_r != CNT_MAX) begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end

  // transmit shift after clock rises; line released at frame end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_r <= '0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (sel_fall && enable) begin
      tx_r <= tx_word;
      sdo <= tx_word[0];
      sdo_oe <= 1'b1;
    end else if (active_r && (sel_rise || !enable)) begin
      sdo_oe <= 1'b0;
    end else if (active_r && sclk_rise) begin
      tx_r <= tx_r >> 1;
      sdo <= tx_r[1];
    end
  end

  // end-of-frame verdict, one pulse on the select rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_end <= 1'b0;
      frame_ok <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      frame_end <= active_r && sel_rise && enable;
      frame_ok <= (cnt_r == CNT_FULL) && !clkhi_r && !sclk_s;
      frame_err <= ((cnt_r != CNT_FULL) && (cnt_r != '0)) || clkhi_r || sclk_s;
    end
  end
endmodule : sscc_shifter

// [testbench/sscc_top_chk.sv]
// sscc_top_chk: port-level assertions for the serial command checker
// assumes: bound into sscc_top, one pclk domain
`timescale 1ns/10ps
module sscc_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic select_low_input,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic fail_safe_req,
  input wire logic interrupt_out_low,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // serial pin relations
  a_oe_sel_low: assert property ($rose(sdo_oe) |-> !select_low_input)
    else $error("sdo enabled while select high");
  a_oe_release: assert property ($rose(select_low_input) |-> ##[1:8] !sdo_oe)
    else $error("sdo not released after select rise");
  a_sdo_on_rise: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> sclk)
    else $error("sdo moved without serial clock high");
  a_off_fsafe: assert property (fail_safe_req [*8] |-> !sdo_oe)
    else $error("serial port active in fail-safe");
  a_int_decode: assert property ($fell(interrupt_out_low) |-> select_low_input)
    else $error("interrupt raised inside a frame");
  // apb answer relations
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("no ready in access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held beyond one cycle");
  a_err_ready: assert property (pslverr |-> pready && psel)
    else $error("error without ready");
  c_int: cover property (!interrupt_out_low);
  c_frame: cover property ($fell(sdo_oe));
  c_slverr: cover property (pready && pslverr);
endmodule : sscc_top_chk

bind sscc_top sscc_top_chk u_chk (.pclk(pclk), .presetn(presetn),
  .select_low_input(select_low_input), .sclk(sclk), .sdo(sdo), .sdo_oe(sdo_oe),
  .fail_safe_req(fail_safe_req), .interrupt_out_low(interrupt_out_low),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr));

// [testbench/sscc_host.sv]
// sscc_host: serial master model, lsb first, sclk idle low, 160 ns period
// assumes: pclk at 5 ns paces the pins, one frame at a time
`timescale 1ns/10ps
module sscc_host (
  input wire logic pclk,
  output logic select_low_input,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    select_low_input = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // one frame of n clocks; data set mid low phase so it never moves with a fall
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
    r = '0;
    @(posedge pclk);
    select_low_input <= 1'b0;
    repeat (16) @(posedge pclk);
    r[0] = sdo;
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge pclk);
      sdi <= w[i];
      repeat (8) @(posedge pclk);
      sclk <= 1'b1;
      repeat (16) @(posedge pclk);
      sclk <= 1'b0;
      if (i < 31) r[i + 1] = sdo;
    end
    repeat (16) @(posedge pclk);
    select_low_input <= 1'b1;
    sdi <= ~sdi;
    repeat (16) @(posedge pclk);
  endtask : xfer
endmodule : sscc_host

// [testbench/spi_slave_command_checker_test.sv]
// spi_slave_command_checker_test: apb and serial scenarios on sscc_top
// assumes: sscc_host drives the serial pins, checker bound to the dut
`timescale 1ns/10ps
module spi_slave_command_checker_test import sscc_pkg::*; ();
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic fail_safe_req = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q, r;
  logic pready, pslverr, sdo, sdo_oe, interrupt_out_low, select_low_input, sclk, sdi;
  logic oe_seen = 1'b0;
  logic e;
  int fail_count = 0;
  int num_checks = 0;
  localparam logic [31:0] CLR = 32'h000000c1;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (sdo_oe === 1'b1) oe_seen <= 1'b1;
  sscc_top dut (.pclk(pclk), .presetn(presetn), .select_low_input(select_low_input),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .wake_pin(1'b0),
    .fail_safe_req(fail_safe_req), .checksum_strap_pin(1'b0),
    .interrupt_out_low(interrupt_out_low), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sscc_host host (.pclk(pclk), .select_low_input(select_low_input), .sclk(sclk),
    .sdi(sdi), .sdo(sdo));
  function automatic logic [31:0] fw(input logic [6:0] a, input logic [15:0] d);
    return {8'h00, d, 1'b1, a};
  endfunction : fw
  task automatic chk(input string s, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", s, ex, got);
    end
  endtask : chk
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic x(input logic [31:0] w, input int n = 32);
    host.xfer(w, n, r);
    repeat (10) @(posedge pclk);
  endtask : x
  task automatic st(input logic [3:0] ex);
    apb(1'b0, APB_STATUS, 32'h0);
    chk("status", 32'(ex), 32'(q[3:0]));
  endtask : st
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    give_verdict;
  end
  // main sequence
  initial begin
    logic [31:0] bad [6];
    bad[0] = fw(A_TIMER, 16'h0505);
    bad[1] = fw(A_WD, 16'h0001);
    bad[2] = fw(A_HS, 16'h0001);
    bad[3] = 32'hffffffff;
    bad[4] = fw(A_PIN, 16'h0000);
    bad[5] = fw(A_MODE, 16'h0005);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    st({1'b0, M_INIT});
    x(fw(A_MODE, 16'h0000));
    st({1'b0, M_NORMAL});
    apb(1'b0, APB_LAST_CMD, 32'h0);
    chk("last word", fw(A_MODE, 16'h0000), q);
    x(32'h0);
    st({1'b1, M_NORMAL});
    x(32'h00000041);
    st({1'b1, M_NORMAL});
    x(CLR);
    st({1'b0, M_NORMAL});
    x(fw(A_PIN, 16'h0000));
    foreach (bad[i]) begin
      x(bad[i]);
      st({1'b1, M_NORMAL});
      x(CLR);
    end
    x(fw(A_WD, 16'h0003));
    apb(1'b0, APB_STATUS, 32'h0);
    chk("wd count", 32'h1, 32'(q[15:8]));
    x(fw(7'h10, 16'h1234));
    st({1'b0, M_NORMAL});
    x(fw(A_MODE, 16'h0001));
    st({1'b0, M_STOP});
    x(fw(A_WAKE_EN, 16'h0002));
    st({1'b1, M_STOP});
    apb(1'b0, APB_CONFIG, 32'h0);
    chk("config", 32'h0, q);
    x(CLR);
    x(fw(A_MODE, 16'h0008));
    st({1'b0, M_NORMAL});
    x(32'h00000001);
    apb(1'b1, APB_WAKE_SET, 32'h1);
    x(fw(A_MODE, 16'h0001));
    chk("mode other", 32'h0001, 32'(r[23:8]));
    st({1'b0, M_STOP});
    chk("irq", 32'h0, 32'(interrupt_out_low));
    x(fw(A_MODE, 16'h0002));
    st({1'b1, M_RESTART});
    oe_seen <= 1'b0;
    x(fw(A_MODE, 16'h0000));
    chk("oe restart", 32'h0, 32'(oe_seen));
    repeat (2100) @(posedge pclk);
    st({1'b1, M_NORMAL});
    fail_safe_req <= 1'b1;
    oe_seen <= 1'b0;
    x(fw(A_MODE, 16'h0000));
    chk("oe fsafe", 32'h0, 32'(oe_seen));
    apb(1'b0, APB_STATUS, 32'h0);
    chk("fsafe", 32'(M_FAILSAFE), 32'(q[2:0]));
    fail_safe_req <= 1'b0;
    repeat (2100) @(posedge pclk);
    x(CLR);
    x(fw(A_MODE, 16'h0001), 5);
    x(32'h00000041);
    chk("err bit", 32'h1, 32'(r[0]));
    st({1'b0, M_NORMAL});
    apb(1'b0, 12'h100, 32'h0);
    chk("slverr", 32'h1, 32'(e));
    give_verdict;
  end
endmodule : spi_slave_command_checker_test
